// File: design/wwd_pkg.sv
// package of constants and types for the windowed watchdog
package wwd_pkg;
	localparam logic [7:0] KEY_VALUE = 8'hAC;
	localparam logic [7:0] READ_ENABLED = 8'h9A;
	localparam logic [7:0] READ_DISABLED = 8'h1A;
	localparam logic [15:0] EXEMPT_A_LO = 16'hFB00;
	localparam logic [15:0] EXEMPT_A_HI = 16'hFFCF;
	localparam logic [15:0] EXEMPT_B_LO = 16'hFFE0;
	localparam int OVF_BASE_EXP = 10;
	localparam int CNT_WIDTH = 17;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SYNC_SLACK_RL = 2;
	// option byte field positions
	localparam int OPT_LOCK_BIT = 0;
	localparam int OPT_OVF_LSB = 1;
	localparam int OPT_ENABLE_BIT = 4;
	localparam int OPT_WIN_LSB = 5;
	localparam int RESET_CAUSE_REG_DOG_BIT = 4;
	// register map on the AHB-Lite slave (byte addresses)
	localparam logic [7:0] ADDR_SERVICE = 8'h00;
	localparam logic [7:0] ADDR_OPTION = 8'h04;
	localparam logic [7:0] ADDR_OSC_MODE = 8'h08;
	localparam logic [7:0] ADDR_MEM_SIZE = 8'h0C;
	localparam logic [7:0] ADDR_RESET_CAUSE = 8'h10;
	localparam logic [7:0] ADDR_COUNT = 8'h14;
	localparam int OSC_HALT_BIT = 1;
	localparam logic [7:0] OPTION_RESET = 8'h10;
	localparam logic [7:0] MEM_SIZE_RESET = 8'hCF;
	// cpu activity carrier
	typedef struct packed {
		logic fetch;
		logic access;
		logic [15:0] addr;
		logic bitOp;
	} wwd_cpu_t;
	typedef enum logic [1:0] {
		SVC_WRITE = 2'b00,
		SVC_READ = 2'b01,
		SVC_IDLE = 2'b10
	} wwd_op_t;
endpackage

// File: design/wwd_top.sv
// windowed watchdog timer with AHB-Lite register slave
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module wwd_top #(
	parameter int CNT_W = 17 // counter width, holds 2^17 periods
) (
	input wire logic clk, // system clock, 50 MHz
	input wire logic reset, // asynchronous reset, active high
	input wire logic clkEn, // clock enable, freezes all state when low
	input wire logic slowTick, // one-cycle pulse per slow oscillator period
	input wire logic haltMode, // cpu in HALT
	input wire logic stopMode, // cpu in STOP
	input wire logic flashSelfProg, // flash self-programming in progress
	input wire wwd_pkg::wwd_cpu_t cpuBus, // cpu fetch/access monitor
	input wire logic hsel, // AHB select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response, always OKAY
	output logic resetReq, // one-cycle internal reset request
	output logic [CNT_W-1:0] countOut // current counter value
);
	initial begin
		if (CNT_W != wwd_pkg::CNT_WIDTH) $error("counter width must be 17");
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] optionByte;
	logic [7:0] oscMode;
	logic [7:0] memSize;
	logic [7:0] resetCause;
	logic [CNT_W-1:0] count;
	logic firstDone;
	logic pendingEvt;
	logic aPhase;
	logic aWrite;
	logic [7:0] aAddr;
	logic aByte;
	logic aBit;

	// option fields
	wire logic countEnable = optionByte[wwd_pkg::OPT_ENABLE_BIT];
	wire logic oscLock = optionByte[wwd_pkg::OPT_LOCK_BIT];
	wire logic [2:0] ovfCode = optionByte[wwd_pkg::OPT_OVF_LSB +: 3];
	wire logic [1:0] winCode = optionByte[wwd_pkg::OPT_WIN_LSB +: 2];

	// overflow count and window open point
	function automatic logic [CNT_W:0] ovfLimit(input logic [2:0] code);
		ovfLimit = (CNT_W+1)'(1) << (wwd_pkg::OVF_BASE_EXP + int'(code));
	endfunction

	logic [CNT_W:0] limit;
	logic [CNT_W:0] openPoint;
	always_comb begin
		limit = ovfLimit(ovfCode);
		// closed window ends at (1 - fraction) of overflow
		case (winCode)
			2'b00: openPoint = (limit >> 1) + (limit >> 2);
			2'b01: openPoint = limit >> 1;
			2'b10: openPoint = limit >> 2;
			default: openPoint = '0;
		endcase
	end

	// slow clock stopped when lock is off and in HALT/STOP or halted by software
	wire logic srcStopped = !oscLock && (haltMode || stopMode || oscMode[wwd_pkg::OSC_HALT_BIT]);
	wire logic running = countEnable && !srcStopped;

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite address phase capture; answers in the cycle after address
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			aPhase <= 1'b0;
			aWrite <= 1'b0;
			aAddr <= 8'h00;
			aByte <= 1'b0;
			aBit <= 1'b0;
		end else if (clkEn && hready) begin
			aPhase <= hsel && htrans[1];
			aWrite <= hwrite;
			aAddr <= haddr[7:0];
			aByte <= (hsize == 3'b000);
			aBit <= cpuBus.bitOp;
		end
	end

	wire logic svcWrite = aPhase && aWrite && aAddr == wwd_pkg::ADDR_SERVICE;
	wire logic [7:0] wData = hwdata[7:0];
	wire logic keyOk = aByte && !aBit && wData == wwd_pkg::KEY_VALUE;
	wire logic inClosed = {1'b0, count} < openPoint;

	// address checks against configured areas, exempt windows excluded for data accesses only, not for fetches
	function automatic logic outOfArea(input logic [15:0] a, input logic [7:0] ms);
		logic [15:0] romTop;
		romTop = {ms[3:0], 12'h000};
		outOfArea = a >= romTop && a < {ms[7:4], 12'hF00};
	endfunction
	function automatic logic exempt(input logic [15:0] a);
		exempt = (a >= wwd_pkg::EXEMPT_A_LO && a <= wwd_pkg::EXEMPT_A_HI) ||
			a >= wwd_pkg::EXEMPT_B_LO;
	endfunction

	// event detection
	logic evt;
	always_comb begin
		evt = 1'b0;
		if (svcWrite) begin
			if (aBit) evt = 1'b1;
			else if (!keyOk) evt = 1'b1;
			else if (firstDone && inClosed) evt = 1'b1;
		end
		if (countEnable && cpuBus.fetch && outOfArea(cpuBus.addr, memSize)) evt = 1'b1;
		if (countEnable && cpuBus.access && outOfArea(cpuBus.addr, memSize) &&
			!exempt(cpuBus.addr)) evt = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// counter, clear and overflow
	wire logic validClear = svcWrite && !evt && countEnable;
	wire logic overflow = running && slowTick && ({1'b0, count} + 1'b1 >= limit) && !validClear;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count <= '0;
			firstDone <= 1'b0;
		end else if (clkEn) begin
			if (validClear) begin
				count <= '0;
				firstDone <= 1'b1;
			end else if (overflow) begin
				count <= '0;
			end else if (running && slowTick) begin
				count <= count + 1'b1;
			end
			if (svcWrite) firstDone <= 1'b1;
		end
	end

	// reset request: immediate, or deferred until slow clock resumes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			resetReq <= 1'b0;
			pendingEvt <= 1'b0;
		end else if (clkEn) begin
			resetReq <= 1'b0;
			if ((evt || pendingEvt) && srcStopped) pendingEvt <= 1'b1;
			else if (evt || pendingEvt || overflow) begin
				resetReq <= 1'b1;
				pendingEvt <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			optionByte <= wwd_pkg::OPTION_RESET;
			oscMode <= 8'h00;
			memSize <= wwd_pkg::MEM_SIZE_RESET;
			resetCause <= 8'h00;
		end else if (clkEn) begin
			if (aPhase && aWrite) begin
				case (aAddr)
					wwd_pkg::ADDR_OPTION: optionByte <= wData;
					wwd_pkg::ADDR_OSC_MODE: oscMode <= wData;
					wwd_pkg::ADDR_MEM_SIZE: memSize <= wData;
					wwd_pkg::ADDR_RESET_CAUSE: resetCause <= wData;
					default: ;
				endcase
			end
			if (evt || pendingEvt || overflow) resetCause[wwd_pkg::RESET_CAUSE_REG_DOG_BIT] <= 1'b1;
		end
	end

	// read mux and bus outputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			countOut <= '0;
		end else if (clkEn) begin
			countOut <= count;
			hrdata <= 32'h0000_0000;
			if (hsel && htrans[1] && !hwrite && hready) begin
				case (haddr[7:0])
					wwd_pkg::ADDR_SERVICE: hrdata <= {24'h0, countEnable ?
						wwd_pkg::READ_ENABLED : wwd_pkg::READ_DISABLED};
					wwd_pkg::ADDR_OPTION: hrdata <= {24'h0, optionByte};
					wwd_pkg::ADDR_OSC_MODE: hrdata <= {24'h0, oscMode};
					wwd_pkg::ADDR_MEM_SIZE: hrdata <= {24'h0, memSize};
					wwd_pkg::ADDR_RESET_CAUSE: hrdata <= {24'h0, resetCause};
					wwd_pkg::ADDR_COUNT: hrdata <= 32'(count);
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	sequence s_badWrite;
		clkEn && svcWrite && !keyOk && !srcStopped;
	endsequence
	a_bad_key_reset: assert property (@(posedge clk) disable iff (reset)
		s_badWrite |=> resetReq) else $error("bad key did not reset");
	a_clear_zeroes: assert property (@(posedge clk) disable iff (reset)
		clkEn && validClear |=> count == '0) else $error("key write did not clear");
	a_closed_win: assert property (@(posedge clk) disable iff (reset)
		clkEn && svcWrite && keyOk && firstDone && inClosed && !srcStopped |=> resetReq)
		else $error("closed window write missed");
	a_freeze_hold: assert property (@(posedge clk) disable iff (reset)
		srcStopped && !validClear |=> $stable(count)) else $error("counter moved while stopped");
	a_disabled_stop: assert property (@(posedge clk) disable iff (reset)
		!countEnable |=> $stable(count) || count == '0) else $error("counting while disabled");
	a_ovf_reset: assert property (@(posedge clk) disable iff (reset)
		clkEn && overflow |=> resetReq && count == '0) else $error("overflow no reset");
	a_flag_set: assert property (@(posedge clk) disable iff (reset)
		clkEn && resetReq |-> resetCause[wwd_pkg::RESET_CAUSE_REG_DOG_BIT]) else $error("flag not set");
	a_pulse_one: assert property (@(posedge clk) disable iff (reset)
		resetReq && !pendingEvt && !evt && !overflow |=> !resetReq) else $error("pulse too long");
	a_bit_op: assert property (@(posedge clk) disable iff (reset)
		clkEn && svcWrite && aBit && !srcStopped |=> resetReq) else $error("bit op missed");

	////////////////////////////////////////////////////////////////////////
	// clearing, counting and access guards
	// a correct key write on the service register, no bit operation
	sequence s_keyWrite;
		clkEn && svcWrite && keyOk && !aBit;
	endsequence
	// a slow-clock tick that the counter may use
	sequence s_counting;
		clkEn && running && slowTick;
	endsequence
	// nothing else in the cycle can turn a key write into a reset
	sequence s_quietClear;
		countEnable && !evt && !pendingEvt;
	endsequence

	// the first write clears even inside the closed window
	a_first_clear: assert property (@(posedge clk) disable iff (reset)
		s_keyWrite ##0 s_quietClear ##0 !firstDone |=> count == '0)
		else $error("first key write did not clear");
	// a clear on the tick that would overflow still wins
	a_last_clear: assert property (@(posedge clk) disable iff (reset)
		s_keyWrite ##0 s_quietClear ##0 s_counting ##0 ({1'b0, count} + 1'b1 >= limit)
		|=> count == '0 && !resetReq) else $error("last-count clear lost");
	// each used tick without a clear or overflow moves the counter by exactly one
	a_count_step: assert property (@(posedge clk) disable iff (reset)
		s_counting ##0 (!validClear && !overflow) |=> count == $past(count) + 1'b1)
		else $error("counter step wrong");

	// without the lock, software halt of the slow oscillator holds the count
	a_osc_halt: assert property (@(posedge clk) disable iff (reset)
		!oscLock && oscMode[wwd_pkg::OSC_HALT_BIT] && !validClear |=> $stable(count))
		else $error("count moved with oscillator halted");
	// without the lock, low-power modes stop counting
	a_halt_stops: assert property (@(posedge clk) disable iff (reset)
		!oscLock && (haltMode || stopMode) |-> !running) else $error("counting in low power");
	// with the lock set, low-power modes do not stop counting
	a_lock_run: assert property (@(posedge clk) disable iff (reset)
		oscLock && countEnable && (haltMode || stopMode) |-> running)
		else $error("locked oscillator stopped");
	// flash self-programming never stops the counter
	a_flash_run: assert property (@(posedge clk) disable iff (reset)
		flashSelfProg && countEnable && !srcStopped |-> running)
		else $error("counter stopped during flash work");

	// fetch outside the configured areas resets
	a_fetch_reset: assert property (@(posedge clk) disable iff (reset)
		clkEn && countEnable && cpuBus.fetch && outOfArea(cpuBus.addr, memSize) && !srcStopped
		|=> resetReq) else $error("bad fetch did not reset");
	// data access outside the areas resets unless exempt
	a_access_reset: assert property (@(posedge clk) disable iff (reset)
		clkEn && countEnable && cpuBus.access && outOfArea(cpuBus.addr, memSize) &&
		!exempt(cpuBus.addr) && !srcStopped |=> resetReq) else $error("bad access did not reset");
	// with counting disabled no access check fires
	a_detect_off: assert property (@(posedge clk) disable iff (reset)
		clkEn && !countEnable && !svcWrite && !pendingEvt |=> !resetReq)
		else $error("detection while disabled");

	// service register reads the fixed pattern, never the key
	a_read_value: assert property (@(posedge clk) disable iff (reset)
		clkEn && hsel && htrans[1] && !hwrite && hready && haddr[7:0] == wwd_pkg::ADDR_SERVICE
		|=> hrdata[7:0] == ($past(countEnable) ?
		wwd_pkg::READ_ENABLED : wwd_pkg::READ_DISABLED)) else $error("service read wrong");

	// open points of the four window codes
	a_open_always: assert property (@(posedge clk) disable iff (reset)
		winCode == 2'b11 |-> openPoint == '0) else $error("full window not open");
	a_open_half: assert property (@(posedge clk) disable iff (reset)
		winCode == 2'b01 |-> openPoint == (limit >> 1)) else $error("half window wrong");
	a_open_three: assert property (@(posedge clk) disable iff (reset)
		winCode == 2'b10 |-> openPoint == (limit >> 2)) else $error("wide window wrong");
	a_open_quarter: assert property (@(posedge clk) disable iff (reset)
		winCode == 2'b00 |-> openPoint == limit - (limit >> 2)) else $error("narrow window wrong");
endmodule
`default_nettype wire

// File: tb/wwd_cpu_model.sv
// cpu-side partner: AHB-Lite master plus fetch/access pulses
`timescale 1ns/1ps
`default_nettype none
module wwd_cpu_model (
	input wire logic clk, // system clock
	input wire logic hready, // bus ready
	input wire logic [31:0] hrdata, // read data
	output logic hsel, // select
	output logic [31:0] haddr, // address
	output logic [1:0] htrans, // transfer type
	output logic hwrite, // write
	output logic [2:0] hsize, // size
	output logic [31:0] hwdata, // write data
	output wwd_pkg::wwd_cpu_t cpuBus // fetch/access monitor
);
	// idle bus at time zero
	initial begin
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h0;
		hwdata = 32'h0;
		cpuBus = '0;
	end
	////////////////////////////////////////////////////////////////
	// one single transfer; bitOp rides with the address phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [2:0] sz,
		input logic [31:0] d, input logic bo, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= sz;
		cpuBus.bitOp <= bo;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		cpuBus.bitOp <= 1'h0;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	// one fetch or data access pulse
	task automatic pulse(input logic f, input logic [15:0] a);
		@(posedge clk);
		cpuBus.fetch <= f;
		cpuBus.access <= ~f;
		cpuBus.addr <= a;
		@(posedge clk);
		cpuBus.fetch <= 1'h0;
		cpuBus.access <= 1'h0;
	endtask
endmodule
`default_nettype wire

// File: tb/windowed_watchdog_timer_tb_top.sv
// self-checking testbench of the windowed watchdog
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer_tb_top;
	logic clk = 1'h0, reset = 1'h1, clkEn = 1'h1, slowTick = 1'h0, tickOn = 1'h0;
	logic haltMode = 1'h0, stopMode = 1'h0, flashSelfProg = 1'h0;
	logic hsel, hwrite, hreadyout, hresp, resetReq;
	logic [31:0] haddr, hwdata, hrdata, rd, held;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [16:0] countOut;
	wwd_pkg::wwd_cpu_t cpuBus;
	int errors = 0, checks = 0, reqs = 0, base = 0, n;
	////////////////////////////////////////////////////////////////
	wwd_top #(.CNT_W(17)) dut (.clk(clk), .reset(reset), .clkEn(clkEn), .slowTick(slowTick),
		.haltMode(haltMode), .stopMode(stopMode), .flashSelfProg(flashSelfProg),
		.cpuBus(cpuBus), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .resetReq(resetReq), .countOut(countOut));
	wwd_cpu_model cpu (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.cpuBus(cpuBus));
	// clock, slow tick every other cycle, reset request counter
	always #10 clk = ~clk;
	always @(posedge clk) slowTick <= tickOn & ~slowTick;
	always @(negedge clk) if (resetReq === 1'b1) reqs++;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		cpu.xfer(1'h1, a, 3'h2, d, 1'h0, rd);
		repeat (2) @(posedge clk);
	endtask
	task automatic svc(input logic [7:0] d, input logic bo);
		cpu.xfer(1'h1, wwd_pkg::ADDR_SERVICE, 3'h0, {24'h0, d}, bo, rd);
		repeat (2) @(posedge clk);
	endtask
	task automatic rdr(input logic [7:0] a);
		cpu.xfer(1'h0, a, 3'h2, 32'h0, 1'h0, rd);
	endtask
	// reset requests seen since the last call
	task automatic req_chk(input int e);
		repeat (4) @(posedge clk);
		chk(32'(reqs - base), 32'(e));
		base = reqs;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_first;
		rdr(wwd_pkg::ADDR_SERVICE);
		chk(rd, 32'h9A);
		wr(wwd_pkg::ADDR_OPTION, 32'h12);
		repeat (20) @(posedge clk);
		svc(8'hAC, 1'h0);
		chk(32'(countOut <= 17'h2), 32'h1);
		req_chk(0);
		svc(8'hAC, 1'h0);
		req_chk(1);
		rdr(wwd_pkg::ADDR_RESET_CAUSE);
		chk(32'(rd[4]), 32'h1);
	endtask
	task automatic t_keys;
		wr(wwd_pkg::ADDR_OPTION, 32'h70);
		svc(8'h55, 1'h0);
		req_chk(1);
		svc(8'hAC, 1'h1);
		req_chk(1);
		repeat (30) @(posedge clk);
		svc(8'hAC, 1'h0);
		chk(32'(countOut <= 17'h2), 32'h1);
		req_chk(0);
	endtask
	task automatic t_ovf;
		svc(8'hAC, 1'h0);
		n = 0;
		for (int i = 0; i < 3000 && resetReq !== 1'b1; i++) begin
			@(posedge clk);
			if (slowTick === 1'b1) n++;
		end
		chk(32'(n >= 1022 && n <= 1026), 32'h1);
		req_chk(1);
	endtask
	task automatic t_freeze;
		svc(8'hAC, 1'h0);
		haltMode <= 1'h1;
		repeat (2) @(posedge clk);
		held = 32'(countOut);
		repeat (40) @(posedge clk);
		chk(32'(countOut), held);
		haltMode <= 1'h0;
		repeat (40) @(posedge clk);
		chk(32'(countOut > held && countOut <= held + 22), 32'h1);
		wr(wwd_pkg::ADDR_OSC_MODE, 32'h2);
		held = 32'(countOut);
		repeat (40) @(posedge clk);
		chk(32'(countOut), held);
		wr(wwd_pkg::ADDR_OSC_MODE, 32'h0);
		wr(wwd_pkg::ADDR_OPTION, 32'h71);
		svc(8'hAC, 1'h0);
		stopMode <= 1'h1;
		flashSelfProg <= 1'h1;
		held = 32'(countOut);
		repeat (40) @(posedge clk);
		chk(32'(countOut > held), 32'h1);
		stopMode <= 1'h0;
		flashSelfProg <= 1'h0;
		req_chk(0);
	endtask
	task automatic t_mem;
		svc(8'hAC, 1'h0);
		wr(wwd_pkg::ADDR_MEM_SIZE, 32'hF8);
		cpu.pulse(1'h1, 16'h9000);
		req_chk(1);
		cpu.pulse(1'h0, 16'hA000);
		req_chk(1);
		cpu.pulse(1'h0, 16'hFB10);
		req_chk(0);
		cpu.pulse(1'h1, 16'hFB10);
		req_chk(1);
	endtask
	task automatic t_off;
		wr(wwd_pkg::ADDR_OPTION, 32'h0);
		rdr(wwd_pkg::ADDR_SERVICE);
		chk(rd, 32'h1A);
		cpu.pulse(1'h1, 16'h9000);
		req_chk(0);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		if (errors == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// reset, then the scenarios in order
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		tickOn <= 1'h1;
		t_first;
		t_keys;
		t_ovf;
		t_freeze;
		t_mem;
		t_off;
		report_and_stop;
	end
	// watchdog on the bench itself
	initial begin
		#1ms;
		errors++;
		report_and_stop;
	end
endmodule
`default_nettype wire
